/* File: verilog/wdc_pkg.sv */
package wdc_pkg;

  // ------------------------------------------------
  // Register byte offsets on the APB bus.
  // ------------------------------------------------
  localparam logic [7:0] OFS_OSC = 8'h00;
  localparam logic [7:0] OFS_OSC_INV = 8'h04;
  localparam logic [7:0] OFS_LIM = 8'h08;
  localparam logic [7:0] OFS_LIM_INV = 8'h0c;
  localparam logic [7:0] OFS_TIM = 8'h10;
  localparam logic [7:0] OFS_TIM_INV = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;

  // ------------------------------------------------
  // Field positions (low bit of each field).
  // ------------------------------------------------
  localparam int ERR_LIM_LSB = 14;
  localparam int RFR_LIM_LSB = 11;
  localparam int IMPACT_LSB = 8;
  localparam int RFR_CNT_LSB = 4;
  localparam int ERR_CNT_LSB = 0;
  localparam int WIN_LSB = 12;
  localparam int SPLIT_LSB = 8;
  localparam int OSC_LSB = 0;

  // ------------------------------------------------
  // Reset values: fields zero, complements inverse.
  // ------------------------------------------------
  localparam logic [1:0] RST_2B = 2'h0;
  localparam logic [2:0] RST_3B = 3'h0;
  localparam logic [3:0] RST_4B = 4'h0;
  localparam logic [2:0] IRQ_NONE = 3'h0;

  // Interrupt status bit positions.
  localparam int EV_GOOD = 0;
  localparam int EV_BAD = 1;
  localparam int EV_FAIL = 2;

  // Failure consequence codes.
  typedef enum logic [1:0] {
    WDC_STAY_A = 2'b00,
    WDC_INIT_RUN = 2'b01,
    WDC_DEEP_SAFE = 2'b10,
    WDC_STAY_B = 2'b11
  } wdc_impact_type;

  // Settings currently in force.
  typedef struct packed {
    logic [1:0] err_ceiling;
    logic [1:0] rfr_ceiling;
    wdc_impact_type impact;
    logic [3:0] period;
    logic [2:0] split;
    logic [3:0] osc;
  } wdc_cfg_type;

endpackage

/* File: verilog/wdc_top.sv */
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps

// Notes on behaviour
// [RQ1] Error ceiling codes give 8, 6, 4, 2.
// [RQ2] Error ceiling applies only with inverse match.
// [RQ3] Refresh ceiling codes give 6, 4, 2, 1.
// [RQ4] Refresh ceiling applies only with inverse match.
// [RQ5] Failure steers safety machine per impact code.
// [RQ6] Impact code applies only with inverse match.
// [RQ7] Three-bit refresh tally clears to zero at the ceiling.
// [RQ8] Four-bit fault tally reads current count.
// [RQ9] Window length code applies with inverse match.
// [RQ10] Closed/open split from three-bit code.
// [RQ11] Split code applies only with inverse match.
// [RQ12] Oscillator select applies with inverse match.
// [RQ13] Reset returns every field to default.
// [RQ14] Servicer answers seed or its inverse.
// [RQ15] Mismatch keeps previous applied setting.
module wdc_top (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic good_refresh_i,
  input wire logic bad_refresh_i,
  output logic [10:0] period_ms_o,
  output logic [4:0] closed_16th_o,
  output logic [3:0] osc_sel_o,
  output logic init_run_req_o,
  output logic deep_safe_req_o,
  output logic irq_o
);
  // ------------------------------------------------
  // Written fields and their complements.
  // ------------------------------------------------
  logic [1:0] error_count_ceiling;
  logic [1:0] error_count_ceiling_inv;
  logic [1:0] refresh_count_ceiling;
  logic [1:0] refresh_count_ceiling_inv;
  logic [1:0] failure_consequence;
  logic [1:0] failure_consequence_inv;
  logic [3:0] service_period_length;
  logic [3:0] service_period_length_inv;
  logic [2:0] closed_open_split;
  logic [2:0] closed_open_split_inv;
  logic [3:0] osc_freq_select;
  logic [3:0] osc_freq_select_inv;

  // Settings in force, and the live counters.
  wdc_pkg::wdc_cfg_type cfg;
  logic [2:0] good_refresh_tally;
  logic [3:0] fault_tally;

  // Interrupt status and enable.
  logic [2:0] irq_stat;
  logic [2:0] irq_en;

  // Decoded ceilings and the failure event.
  logic [3:0] err_max;
  logic [2:0] rfr_max;
  logic fail_now;

  // Bus strobes.
  logic wr_en;
  logic rd_en;
  logic [31:0] next_rdata;
  logic next_err;

  // ------------------------------------------------
  // APB slave
  // ------------------------------------------------
  // Strobes fire at the access edge that ends a transfer.
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_en = psel_i & penable_i & pready_o & ~pwrite_i;

  // Ready rises in the access cycle and lasts one cycle: no wait, no stale ready later.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
    end
  end

  // Read mux; fields sit at their positions, others read zero.
  always_comb begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    case (paddr_i)
      wdc_pkg::OFS_OSC: begin
        next_rdata[wdc_pkg::OSC_LSB +: 4] = osc_freq_select;
      end
      wdc_pkg::OFS_OSC_INV: begin
        next_rdata[wdc_pkg::OSC_LSB +: 4] = osc_freq_select_inv;
      end
      wdc_pkg::OFS_LIM: begin
        next_rdata[wdc_pkg::ERR_LIM_LSB +: 2] = error_count_ceiling;
        next_rdata[wdc_pkg::RFR_LIM_LSB +: 2] = refresh_count_ceiling;
        next_rdata[wdc_pkg::IMPACT_LSB +: 2] = failure_consequence;
        next_rdata[wdc_pkg::RFR_CNT_LSB +: 3] = good_refresh_tally; // [RQ7]
        next_rdata[wdc_pkg::ERR_CNT_LSB +: 4] = fault_tally; // [RQ8]
      end
      wdc_pkg::OFS_LIM_INV: begin
        next_rdata[wdc_pkg::ERR_LIM_LSB +: 2] = error_count_ceiling_inv;
        next_rdata[wdc_pkg::RFR_LIM_LSB +: 2] = refresh_count_ceiling_inv;
        next_rdata[wdc_pkg::IMPACT_LSB +: 2] = failure_consequence_inv;
      end
      wdc_pkg::OFS_TIM: begin
        next_rdata[wdc_pkg::WIN_LSB +: 4] = service_period_length;
        next_rdata[wdc_pkg::SPLIT_LSB +: 3] = closed_open_split;
      end
      wdc_pkg::OFS_TIM_INV: begin
        next_rdata[wdc_pkg::WIN_LSB +: 4] = service_period_length_inv;
        next_rdata[wdc_pkg::SPLIT_LSB +: 3] = closed_open_split_inv;
      end
      wdc_pkg::OFS_IRQ_STAT: begin
        next_rdata[2:0] = irq_stat;
      end
      wdc_pkg::OFS_IRQ_CLR: begin
        // Write-only; reads return the zero set above.
      end
      wdc_pkg::OFS_IRQ_EN: begin
        next_rdata[2:0] = irq_en;
      end
      default: begin
        // Unmapped offsets answer with an error.
        next_err = 1'b1;
      end
    endcase
  end

  // Read data and error are registered in the setup cycle.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (psel_i & ~penable_i) begin
      prdata_o <= pwrite_i ? 32'h0 : next_rdata;
      pslverr_o <= next_err;
    end else begin
      pslverr_o <= 1'b0;
    end
  end

  // ------------------------------------------------
  // Written fields
  // ------------------------------------------------
  // Every field and complement returns to default on reset.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      error_count_ceiling <= wdc_pkg::RST_2B; // [RQ13]
      error_count_ceiling_inv <= ~wdc_pkg::RST_2B;
      refresh_count_ceiling <= wdc_pkg::RST_2B;
      refresh_count_ceiling_inv <= ~wdc_pkg::RST_2B;
      failure_consequence <= wdc_pkg::RST_2B;
      failure_consequence_inv <= ~wdc_pkg::RST_2B;
      service_period_length <= wdc_pkg::RST_4B;
      service_period_length_inv <= ~wdc_pkg::RST_4B;
      closed_open_split <= wdc_pkg::RST_3B;
      closed_open_split_inv <= ~wdc_pkg::RST_3B;
      osc_freq_select <= wdc_pkg::RST_4B;
      osc_freq_select_inv <= ~wdc_pkg::RST_4B;
    end else if (wr_en) begin
      case (paddr_i)
        wdc_pkg::OFS_OSC: begin
          osc_freq_select <= pwdata_i[wdc_pkg::OSC_LSB +: 4];
        end
        wdc_pkg::OFS_OSC_INV: begin
          osc_freq_select_inv <= pwdata_i[wdc_pkg::OSC_LSB +: 4];
        end
        wdc_pkg::OFS_LIM: begin
          // The tallies are read-only; their bits are dropped.
          error_count_ceiling <= pwdata_i[wdc_pkg::ERR_LIM_LSB +: 2];
          refresh_count_ceiling <= pwdata_i[wdc_pkg::RFR_LIM_LSB +: 2];
          failure_consequence <= pwdata_i[wdc_pkg::IMPACT_LSB +: 2];
        end
        wdc_pkg::OFS_LIM_INV: begin
          error_count_ceiling_inv <= pwdata_i[wdc_pkg::ERR_LIM_LSB +: 2];
          refresh_count_ceiling_inv <= pwdata_i[wdc_pkg::RFR_LIM_LSB +: 2];
          failure_consequence_inv <= pwdata_i[wdc_pkg::IMPACT_LSB +: 2];
        end
        wdc_pkg::OFS_TIM: begin
          service_period_length <= pwdata_i[wdc_pkg::WIN_LSB +: 4];
          closed_open_split <= pwdata_i[wdc_pkg::SPLIT_LSB +: 3];
        end
        wdc_pkg::OFS_TIM_INV: begin
          service_period_length_inv <= pwdata_i[wdc_pkg::WIN_LSB +: 4];
          closed_open_split_inv <= pwdata_i[wdc_pkg::SPLIT_LSB +: 3];
        end
        default: begin
          // Other offsets hold no field here.
        end
      endcase
    end
  end

  // ------------------------------------------------
  // Applied settings
  // ------------------------------------------------
  // A field is copied only while its complement matches exactly.
  // Checking every cycle lets software write the pair in either order.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg <= '0; // [RQ13]
    end else begin
      if (error_count_ceiling == ~error_count_ceiling_inv) begin
        cfg.err_ceiling <= error_count_ceiling; // [RQ2]
      end
      if (refresh_count_ceiling == ~refresh_count_ceiling_inv) begin
        cfg.rfr_ceiling <= refresh_count_ceiling; // [RQ4]
      end
      if (failure_consequence == ~failure_consequence_inv) begin
        cfg.impact <= wdc_pkg::wdc_impact_type'(failure_consequence); // [RQ6]
      end
      if (service_period_length == ~service_period_length_inv) begin
        cfg.period <= service_period_length; // [RQ9]
      end
      if (closed_open_split == ~closed_open_split_inv) begin
        cfg.split <= closed_open_split; // [RQ11]
      end
      if (osc_freq_select == ~osc_freq_select_inv) begin
        cfg.osc <= osc_freq_select; // [RQ12]
      end
      // A mismatch simply skips the copy, keeping the old value. [RQ15]
    end
  end

  // ------------------------------------------------
  // Ceiling decode
  // ------------------------------------------------
  // Error ceiling in counted errors.
  always_comb begin
    case (cfg.err_ceiling)
      2'b00: err_max = 4'h8; // [RQ1]
      2'b01: err_max = 4'h6;
      2'b10: err_max = 4'h4;
      default: err_max = 4'h2;
    endcase
  end

  // Refresh ceiling in good refreshes.
  always_comb begin
    case (cfg.rfr_ceiling)
      2'b00: rfr_max = 3'h6; // [RQ3]
      2'b01: rfr_max = 3'h4;
      2'b10: rfr_max = 3'h2;
      default: rfr_max = 3'h1;
    endcase
  end

  // ------------------------------------------------
  // Counters
  // ------------------------------------------------
  // Failure fires when a bad refresh brings errors to the ceiling.
  assign fail_now = bad_refresh_i & ((fault_tally + 4'h1) >= err_max);

  // Good refreshes count up; reaching the ceiling forgives one error.
  // A bad refresh wins if both pulses arrive together.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      good_refresh_tally <= wdc_pkg::RST_3B; // [RQ13]
      fault_tally <= wdc_pkg::RST_4B;
    end else if (bad_refresh_i) begin
      good_refresh_tally <= wdc_pkg::RST_3B;
      if (fail_now) begin
        fault_tally <= wdc_pkg::RST_4B;
      end else if (fault_tally != 4'hf) begin
        fault_tally <= fault_tally + 4'h1; // [RQ8]
      end
    end else if (good_refresh_i) begin
      if ((good_refresh_tally + 3'h1) >= rfr_max) begin
        good_refresh_tally <= wdc_pkg::RST_3B;
        if (fault_tally != 4'h0) begin
          fault_tally <= fault_tally - 4'h1;
        end
      end else begin
        // Below the ceiling (at most 6) the 3-bit add never reaches 7, so it never wraps.
        good_refresh_tally <= good_refresh_tally + 3'h1; // [RQ7]
      end
    end
  end

  // ------------------------------------------------
  // Failure consequence
  // ------------------------------------------------
  // Codes 00 and 11 leave the safety machine alone.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      init_run_req_o <= 1'b0;
      deep_safe_req_o <= 1'b0;
    end else begin
      init_run_req_o <= fail_now & (cfg.impact == wdc_pkg::WDC_INIT_RUN); // [RQ5]
      deep_safe_req_o <= fail_now & (cfg.impact == wdc_pkg::WDC_DEEP_SAFE); // [RQ5]
    end
  end

  // ------------------------------------------------
  // Timing outputs
  // ------------------------------------------------
  // Window length in ms; zero means the window is infinite.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      period_ms_o <= 11'h0;
    end else begin
      case (cfg.period)
        4'h1: period_ms_o <= 11'h1; // [RQ9]
        4'h2: period_ms_o <= 11'h2;
        4'h3: period_ms_o <= 11'h3;
        4'h4: period_ms_o <= 11'h4;
        4'h5: period_ms_o <= 11'h6;
        4'h6: period_ms_o <= 11'h8;
        4'h7: period_ms_o <= 11'hc;
        4'h8: period_ms_o <= 11'h10;
        4'h9: period_ms_o <= 11'h18;
        4'ha: period_ms_o <= 11'h20;
        4'hb: period_ms_o <= 11'h40;
        4'hc: period_ms_o <= 11'h80;
        4'hd: period_ms_o <= 11'h100;
        4'he: period_ms_o <= 11'h200;
        4'hf: period_ms_o <= 11'h400;
        default: period_ms_o <= 11'h0;
      endcase
    end
  end

  // Closed part of the window in sixteenths; the rest is open.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      closed_16th_o <= 5'h5;
    end else begin
      case (cfg.split)
        3'h0: closed_16th_o <= 5'h5; // [RQ10]
        3'h1: closed_16th_o <= 5'h6;
        3'h3: closed_16th_o <= 5'ha;
        3'h4: closed_16th_o <= 5'hb;
        default: closed_16th_o <= 5'h8;
      endcase
    end
  end

  // Oscillator selection in force.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_sel_o <= wdc_pkg::RST_4B;
    end else begin
      osc_sel_o <= cfg.osc; // [RQ12]
    end
  end

  // ------------------------------------------------
  // Interrupts
  // ------------------------------------------------
  // Sticky status; a new event wins over a clear in the same cycle.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_stat <= wdc_pkg::IRQ_NONE;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_en && paddr_i == wdc_pkg::OFS_IRQ_CLR && pwdata_i[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
      if (good_refresh_i) begin
        irq_stat[wdc_pkg::EV_GOOD] <= 1'b1;
      end
      if (bad_refresh_i) begin
        irq_stat[wdc_pkg::EV_BAD] <= 1'b1;
      end
      if (fail_now) begin
        irq_stat[wdc_pkg::EV_FAIL] <= 1'b1;
      end
    end
  end

  // Enable register.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_en <= wdc_pkg::IRQ_NONE;
    end else if (wr_en && paddr_i == wdc_pkg::OFS_IRQ_EN) begin
      irq_en <= pwdata_i[2:0];
    end
  end

  // Level output, one cycle behind the status it reflects.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_en);
    end
  end
endmodule

/* File: verification/wdc_top_sva.sv */
`timescale 1ns/100ps

// ------------------------------------------------
// Port-level checks for the watchdog settings block.
// ------------------------------------------------
module wdc_chk (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic bad_refresh_i,
  input wire logic [10:0] period_ms_o,
  input wire logic [4:0] closed_16th_o,
  input wire logic [3:0] osc_sel_o,
  input wire logic init_run_req_o,
  input wire logic deep_safe_req_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // A write lands only where the access phase meets ready.
  wire wr_done = psel_i && penable_i && pwrite_i && pready_o;

  sequence s_setup;
    psel_i && !penable_i;
  endsequence

  property p_rdy;
    s_setup |=> pready_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing after setup");

  property p_unmap;
    s_setup ##0 (paddr_i > 8'h20) |=> pslverr_o && pready_o;
  endproperty
  a_unmap: assert property (p_unmap) else $error("no error on unmapped address");

  property p_init;
    init_run_req_o |-> $past(bad_refresh_i, 1);
  endproperty
  a_init: assert property (p_init) else $error("restart request without fault");

  property p_deep;
    deep_safe_req_o |-> $past(bad_refresh_i, 1);
  endproperty
  a_deep: assert property (p_deep) else $error("safe request without fault");

  property p_excl;
    !(init_run_req_o && deep_safe_req_o);
  endproperty
  a_excl: assert property (p_excl) else $error("two failure requests at once");

  // The smallest error ceiling is two, so failures never come back to back.
  property p_gap;
    init_run_req_o || deep_safe_req_o |=> !init_run_req_o && !deep_safe_req_o;
  endproperty
  a_gap: assert property (p_gap) else $error("failure requests adjacent");

  property p_split;
    closed_16th_o inside {5'h05, 5'h06, 5'h08, 5'h0a, 5'h0b};
  endproperty
  a_split: assert property (p_split) else $error("illegal closed share");

  property p_period;
    period_ms_o inside {0, 1, 2, 3, 4, 6, 8, 12, 16, 24, 32, 64, 128, 256, 512, 1024};
  endproperty
  a_period: assert property (p_period) else $error("illegal window length");

  // Settings in force may move only as the result of a register write.
  property p_hold;
    !$stable({period_ms_o, closed_16th_o, osc_sel_o}) |-> $past(wr_done, 2) || $past(wr_done, 3);
  endproperty
  a_hold: assert property (p_hold) else $error("setting moved without write");

  c_init: cover property (init_run_req_o);
  c_deep: cover property (deep_safe_req_o);
  c_err: cover property (pslverr_o);
endmodule

bind wdc_top wdc_chk u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .bad_refresh_i(bad_refresh_i), .period_ms_o(period_ms_o),
  .closed_16th_o(closed_16th_o), .osc_sel_o(osc_sel_o), .init_run_req_o(init_run_req_o),
  .deep_safe_req_o(deep_safe_req_o));

/* File: verification/wdc_top_tb.sv */
`timescale 1ns/100ps

module wdc_top_tb;
  // ------------------------------------------------
  // Stimulus, observed outputs and tallies.
  // ------------------------------------------------
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, good = 0, bad = 0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, q;
  logic rdy, serr, lerr, irq, init_rq, deep_rq;
  logic [10:0] period;
  logic [4:0] closed;
  logic [3:0] osc;
  int mismatches = 0, compares = 0, ninit = 0, ndeep = 0, i0, d0;
  int ms[16] = '{0, 1, 2, 3, 4, 6, 8, 12, 16, 24, 32, 64, 128, 256, 512, 1024};
  int cl[8] = '{5, 6, 8, 10, 11, 8, 8, 8};
  int el[4] = '{8, 6, 4, 2};
  int rl[4] = '{6, 4, 2, 1};

  always #5 clk = ~clk;

  // Failure requests last one cycle, so they are counted at every edge.
  always @(posedge clk) begin
    if (init_rq === 1'b1) ninit++;
    if (deep_rq === 1'b1) ndeep++;
  end

  wdc_top dut (.core_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(serr), .good_refresh_i(good), .bad_refresh_i(bad), .period_ms_o(period),
    .closed_16th_o(closed), .osc_sel_o(osc), .init_run_req_o(init_rq),
    .deep_safe_req_o(deep_rq), .irq_o(irq));

  // ------------------------------------------------
  // Shared helpers.
  // ------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // One bus transfer; the edge before it passes first so psel is never re-raised at once.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Wait for ready however long it takes; only the watchdog ends a hang.
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    q = prd;
    lerr = serr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // Pulse the servicing events for one cycle, then let requests drain.
  task automatic ev(input logic g, input logic b);
    // A good pulse stands for an answer that met the seed rule of the mode.
    good <= g;
    bad <= b;
    @(posedge clk);
    good <= 1'b0;
    bad <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Limits with a matching complement, so the whole setting applies.
  task automatic setlim(input logic [1:0] e, input logic [1:0] r, input logic [1:0] m);
    logic [15:0] v;
    v = {e, 1'b0, r, 1'b0, m, 8'h00};
    wr(wdc_pkg::OFS_LIM, 32'(v));
    wr(wdc_pkg::OFS_LIM_INV, 32'(~v & 16'hdb00));
    repeat (3) @(posedge clk);
  endtask

  // ------------------------------------------------
  // Scenarios.
  // ------------------------------------------------
  task automatic t_reset;
    logic [31:0] rv[6] = '{32'h0, 32'hf, 32'h0, 32'hdb00, 32'h0, 32'hf700};
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4));
      chk(q, rv[i]);
    end
    chk({period, closed, osc, irq}, {11'h0, 5'h05, 4'h0, 1'b0});
    $display("test reset done");
  endtask

  task automatic t_timing;
    logic [15:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {4'(i), 1'b0, 3'(i), 8'h00};
      wr(wdc_pkg::OFS_TIM, 32'(v));
      wr(wdc_pkg::OFS_TIM_INV, 32'(~v & 16'hf700));
      repeat (3) @(posedge clk);
      chk(period, ms[i]);
      chk(closed, cl[i % 8]);
    end
    // A lone write leaves the complement stale, so the old setting stays.
    wr(wdc_pkg::OFS_TIM, 32'h1000);
    repeat (3) @(posedge clk);
    chk({period, closed}, {11'd1024, 5'h08});
    $display("test timing done");
  endtask

  task automatic t_osc;
    wr(wdc_pkg::OFS_OSC, 32'h9);
    wr(wdc_pkg::OFS_OSC_INV, 32'h6);
    repeat (3) @(posedge clk);
    chk(osc, 4'h9);
    wr(wdc_pkg::OFS_OSC, 32'h3);
    repeat (3) @(posedge clk);
    chk(osc, 4'h9);
    $display("test osc done");
  endtask

  task automatic t_err;
    for (int c = 0; c < 4; c++) begin
      setlim(2'(c), 2'h0, 2'h1);
      i0 = ninit;
      for (int k = 1; k < el[c]; k++) ev(1'b0, 1'b1);
      rd(wdc_pkg::OFS_LIM);
      chk(q[3:0], el[c] - 1);
      chk(ninit - i0, 0);
      ev(1'b0, 1'b1);
      rd(wdc_pkg::OFS_LIM);
      chk(q[3:0], 0);
      chk(ninit - i0, 1);
    end
    $display("test error ceiling done");
  endtask

  task automatic t_impact;
    for (int c = 0; c < 4; c++) begin
      setlim(2'h3, 2'h0, 2'(c));
      i0 = ninit;
      d0 = ndeep;
      ev(1'b0, 1'b1);
      ev(1'b0, 1'b1);
      chk(ninit - i0, c == 1);
      chk(ndeep - d0, c == 2);
    end
    // Stale complement: ceiling two and restart impact must stay in force.
    setlim(2'h3, 2'h0, 2'h1);
    wr(wdc_pkg::OFS_LIM, 32'h0);
    i0 = ninit;
    ev(1'b0, 1'b1);
    ev(1'b0, 1'b1);
    chk(ninit - i0, 1);
    $display("test impact done");
  endtask

  task automatic t_rfr;
    for (int c = 0; c < 4; c++) begin
      setlim(2'h0, 2'(c), 2'h0);
      ev(1'b0, 1'b1);
      for (int k = 1; k < rl[c]; k++) ev(1'b1, 1'b0);
      rd(wdc_pkg::OFS_LIM);
      chk(q[6:0], {3'(rl[c] - 1), 4'h1});
      ev(1'b1, 1'b0);
      rd(wdc_pkg::OFS_LIM);
      chk(q[6:0], 7'h00);
    end
    $display("test refresh ceiling done");
  endtask

  task automatic t_irq;
    wr(wdc_pkg::OFS_IRQ_CLR, 32'h7);
    wr(wdc_pkg::OFS_IRQ_EN, 32'h0);
    ev(1'b0, 1'b1);
    rd(wdc_pkg::OFS_IRQ_STAT);
    chk(q, 32'h2);
    chk(irq, 1'b0);
    wr(wdc_pkg::OFS_IRQ_EN, 32'h2);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wr(wdc_pkg::OFS_IRQ_CLR, 32'h2);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    rd(8'h40);
    chk({lerr, q[30:0]}, 32'h80000000);
    $display("test irq done");
  endtask

  task give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_timing;
    t_osc;
    t_err;
    t_impact;
    t_rfr;
    t_irq;
    // A second reset mid-run, with the fault tally and settings away from default.
    ev(1'b0, 1'b1);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    give_verdict;
  end

  // The whole run needs well under a tenth of this span.
  initial begin
    #200us;
    mismatches++;
    give_verdict;
  end
endmodule
